// *** verilog/dlls_pkg.sv ***
package dlls_pkg;
   // ----------------------------------------------------------------
   // register map (AXI4-Lite byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_STATUS  = 8'h04;
   localparam logic [7:0] REG_T_CKSRE = 8'h08;
   localparam logic [7:0] REG_T_CKSRX = 8'h0c;
   localparam logic [7:0] REG_T_XS    = 8'h10;
   localparam logic [7:0] REG_T_MRD   = 8'h14;
   localparam logic [7:0] REG_T_MOD   = 8'h18;
   localparam logic [7:0] REG_T_DLLK  = 8'h1c;
   localparam logic [7:0] REG_T_ZQOP  = 8'h20;
   localparam logic [7:0] REG_MR0     = 8'h24;
   localparam logic [7:0] REG_MR1     = 8'h28;
   localparam logic [7:0] REG_MR2     = 8'h2c;
   // ctrl fields
   localparam int CTRL_GO     = 0;
   localparam int CTRL_TO_ON  = 1;
   localparam int CTRL_ODT_EN = 2;
   localparam int CTRL_ZQ     = 3;
   localparam int CTRL_CLK_OK = 4;
   // mode-register bit positions
   localparam int MR1_DLL_DIS = 0;
   localparam int MR0_DLL_RST = 8;
   localparam int MR0_CL_LSB  = 4;
   localparam int MR2_CWL_LSB = 3;
   // latency codes for 6/6 while the dll is off
   localparam logic [2:0] MR0_CL6 = 3'h2;
   localparam logic [2:0] MR2_CWL6 = 3'h1;
   // ----------------------------------------------------------------
   // timing reset values, in cycles of the 100 ns aclk
   // ----------------------------------------------------------------
   localparam int CLK_PS = 100000;
   localparam int T_CKSRE_PS = 10000;
   localparam int T_CKSRX_PS = 10000;
   localparam int T_XS_PS    = 170000;
   localparam int T_MRD_NCK  = 4;
   localparam int T_MOD_NCK  = 12;
   localparam int T_DLLK_NCK = 512;
   localparam int T_ZQOP_NCK = 256;
   // round up, never below one cycle
   function automatic logic [15:0] ps2cyc(input int ps);
      int c;
      c = (ps + CLK_PS - 1) / CLK_PS;
      if (c < 1)
         c = 1;
      return c[15:0];
   endfunction : ps2cyc
   localparam logic [15:0] RST_CKSRE = ps2cyc(T_CKSRE_PS);
   localparam logic [15:0] RST_CKSRX = ps2cyc(T_CKSRX_PS);
   localparam logic [15:0] RST_XS    = ps2cyc(T_XS_PS);
   localparam logic [15:0] RST_MRD   = 16'(T_MRD_NCK);
   localparam logic [15:0] RST_MOD   = 16'(T_MOD_NCK);
   localparam logic [15:0] RST_DLLK  = 16'(T_DLLK_NCK);
   localparam logic [15:0] RST_ZQOP  = 16'(T_ZQOP_NCK);
   // ----------------------------------------------------------------
   // dram command encodings {cs_n, ras_n, cas_n, we_n}
   // ----------------------------------------------------------------
   localparam logic [3:0] CMD_NOP  = 4'h7;
   localparam logic [3:0] CMD_MRS  = 4'h0;
   localparam logic [3:0] CMD_SRE  = 4'h1;
   localparam logic [3:0] CMD_ZQCL = 4'h6;
   typedef struct packed {
      logic       cke;
      logic       odt;
      logic [3:0] cmd;
      logic [2:0] ba;
      logic [15:0] addr;
   } dlls_pins_s;
   typedef enum logic [3:0] {
      S_IDLE   = 4'h0,
      S_MR1OFF = 4'h1,
      S_SRE    = 4'h2,
      S_CKSRE  = 4'h3,
      S_FREQ   = 4'h4,
      S_CKSRX  = 4'h5,
      S_XS     = 4'h6,
      S_MR1ON  = 4'h7,
      S_MR0RST = 4'h8,
      S_MRUPD  = 4'h9,
      S_ZQ     = 4'ha,
      S_FINAL  = 4'hb,
      S_DONE   = 4'hc
   } dlls_state_e;
endpackage : dlls_pkg

// *** verilog/dlls_timer.sv ***
`timescale 1ns/1ps
// loadable down counter; expired while zero
module dlls_timer #(
   parameter int W = 16
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         load,
   input  wire logic [W-1:0] value,
   output logic              expired
);
   initial begin
      if (W < 2)
         $error("dlls_timer width too small");
   end
   logic [W-1:0] cnt_r;
   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn)
         cnt_r <= '0;
      else if (load)
         cnt_r <= value;
      else if (cnt_r != '0)
         cnt_r <= cnt_r - 1'b1;
   end
   // no load term: the step timer's load is itself decoded from expired
   assign expired = (cnt_r == '0);
endmodule : dlls_timer

// *** verilog/dlls_seq.sv ***
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
module dlls_seq (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [7:0]   s_axi_awaddr,
   input  wire logic         s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire logic [31:0]  s_axi_wdata,
   input  wire logic [3:0]   s_axi_wstrb,
   input  wire logic         s_axi_wvalid,
   output logic              s_axi_wready,
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire logic         s_axi_bready,
   input  wire logic [7:0]   s_axi_araddr,
   input  wire logic         s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire logic         s_axi_rready,
   output dlls_pkg::dlls_pins_s ddr,
   output logic              freq_change_ok,
   output logic              dll_locked,
   output logic              ready_out
);
   dlls_pkg::dlls_state_e state_r;
   logic [15:0] t_cksre_r, t_cksrx_r, t_xs_r, t_mrd_r;
   logic [15:0] t_mod_r, t_dllk_r, t_zqop_r;
   logic [15:0] mr0_r, mr1_r, mr2_r;
   logic        to_on_r, odt_en_r, zq_r, clk_ok_r, go_pulse;
   logic        busy, done_r, zq_issued_r;
   logic        tm_load, tm_exp, dl_load, dl_exp, zq_load, zq_exp;
   logic [15:0] tm_val;
   dlls_pkg::dlls_pins_s ddr_nxt;

   // ----------------------------------------------------------------
   // axi4-lite write path: both channels taken together
   // ----------------------------------------------------------------
   logic wr_go;
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_bresp   = 2'h0;
   assign go_pulse = wr_go && s_axi_awaddr == dlls_pkg::REG_CTRL &&
                     s_axi_wstrb[0] && s_axi_wdata[dlls_pkg::CTRL_GO];

   always_ff @(posedge aclk) begin
      if (!aresetn)
         s_axi_bvalid <= 1'b0;
      else if (wr_go)
         s_axi_bvalid <= 1'b1;
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // low 16 bits only; writes while busy are ignored to keep a run stable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         t_cksre_r <= dlls_pkg::RST_CKSRE;
         t_cksrx_r <= dlls_pkg::RST_CKSRX;
         t_xs_r    <= dlls_pkg::RST_XS;
         t_mrd_r   <= dlls_pkg::RST_MRD;
         t_mod_r   <= dlls_pkg::RST_MOD;
         t_dllk_r  <= dlls_pkg::RST_DLLK;
         t_zqop_r  <= dlls_pkg::RST_ZQOP;
         mr0_r     <= 16'h0000;
         mr1_r     <= 16'h0000;
         mr2_r     <= 16'h0000;
         to_on_r   <= 1'b0;
         odt_en_r  <= 1'b0;
         zq_r      <= 1'b0;
      end else if (wr_go && !busy) begin
         if (s_axi_awaddr == dlls_pkg::REG_CTRL) begin
            to_on_r  <= s_axi_wdata[dlls_pkg::CTRL_TO_ON];
            odt_en_r <= s_axi_wdata[dlls_pkg::CTRL_ODT_EN];
            zq_r     <= s_axi_wdata[dlls_pkg::CTRL_ZQ];
         end else if (s_axi_awaddr == dlls_pkg::REG_T_CKSRE)
            t_cksre_r <= s_axi_wdata[15:0];
         else if (s_axi_awaddr == dlls_pkg::REG_T_CKSRX)
            t_cksrx_r <= s_axi_wdata[15:0];
         else if (s_axi_awaddr == dlls_pkg::REG_T_XS)
            t_xs_r <= s_axi_wdata[15:0];
         else if (s_axi_awaddr == dlls_pkg::REG_T_MRD)
            t_mrd_r <= s_axi_wdata[15:0];
         else if (s_axi_awaddr == dlls_pkg::REG_T_MOD)
            t_mod_r <= s_axi_wdata[15:0];
         else if (s_axi_awaddr == dlls_pkg::REG_T_DLLK)
            t_dllk_r <= s_axi_wdata[15:0];
         else if (s_axi_awaddr == dlls_pkg::REG_T_ZQOP)
            t_zqop_r <= s_axi_wdata[15:0];
         else if (s_axi_awaddr == dlls_pkg::REG_MR0)
            mr0_r <= s_axi_wdata[15:0];
         else if (s_axi_awaddr == dlls_pkg::REG_MR1)
            mr1_r <= s_axi_wdata[15:0];
         else if (s_axi_awaddr == dlls_pkg::REG_MR2)
            mr2_r <= s_axi_wdata[15:0];
      end
   end

   // clock-stable flag: set by software, held only in freq and dropped in any other state
   always_ff @(posedge aclk) begin
      if (!aresetn)
         clk_ok_r <= 1'b0;
      else if (wr_go && s_axi_awaddr == dlls_pkg::REG_CTRL &&
               s_axi_wdata[dlls_pkg::CTRL_CLK_OK])
         clk_ok_r <= 1'b1;
      else if (state_r != dlls_pkg::S_FREQ)
         clk_ok_r <= 1'b0;
   end

   // ----------------------------------------------------------------
   // axi4-lite read path
   // ----------------------------------------------------------------
   function automatic logic [31:0] rd_mux(input logic [7:0] a);
      logic [31:0] d;
      d = 32'h0;
      if (a == dlls_pkg::REG_CTRL)
         d = {28'h0, zq_r, odt_en_r, to_on_r, 1'b0};
      else if (a == dlls_pkg::REG_STATUS)
         d = {22'h0, zq_issued_r, dll_locked, state_r, ready_out,
              freq_change_ok, done_r, busy};
      else if (a == dlls_pkg::REG_T_CKSRE)
         d = {16'h0, t_cksre_r};
      else if (a == dlls_pkg::REG_T_CKSRX)
         d = {16'h0, t_cksrx_r};
      else if (a == dlls_pkg::REG_T_XS)
         d = {16'h0, t_xs_r};
      else if (a == dlls_pkg::REG_T_MRD)
         d = {16'h0, t_mrd_r};
      else if (a == dlls_pkg::REG_T_MOD)
         d = {16'h0, t_mod_r};
      else if (a == dlls_pkg::REG_T_DLLK)
         d = {16'h0, t_dllk_r};
      else if (a == dlls_pkg::REG_T_ZQOP)
         d = {16'h0, t_zqop_r};
      else if (a == dlls_pkg::REG_MR0)
         d = {16'h0, mr0_r};
      else if (a == dlls_pkg::REG_MR1)
         d = {16'h0, mr1_r};
      else if (a == dlls_pkg::REG_MR2)
         d = {16'h0, mr2_r};
      return d;
   endfunction : rd_mux

   assign s_axi_arready = !s_axi_rvalid;
   assign s_axi_rresp   = 2'h0;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux(s_axi_araddr);
      end else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // ----------------------------------------------------------------
   // wait counters
   // ----------------------------------------------------------------
   dlls_timer #(.W(16)) u_step (
      .aclk    (aclk),
      .aresetn (aresetn),
      .load    (tm_load),
      .value   (tm_val),
      .expired (tm_exp)
   );
   dlls_timer #(.W(16)) u_dllk (
      .aclk    (aclk),
      .aresetn (aresetn),
      .load    (dl_load),
      .value   (t_dllk_r),
      .expired (dl_exp)
   );
   dlls_timer #(.W(16)) u_zq (
      .aclk    (aclk),
      .aresetn (aresetn),
      .load    (zq_load),
      .value   (t_zqop_r),
      .expired (zq_exp)
   );

   // ----------------------------------------------------------------
   // sequencer: at most one command per step (none in cksre, freq, xs, final), timer loaded on each issue
   // ----------------------------------------------------------------
   function automatic dlls_pkg::dlls_pins_s mrs(input logic [2:0] ba,
                                                input logic [15:0] a);
      dlls_pkg::dlls_pins_s p;
      p.cke  = 1'b1;
      p.odt  = 1'b0;
      p.cmd  = dlls_pkg::CMD_MRS;
      p.ba   = ba;
      p.addr = a;
      return p;
   endfunction : mrs

   assign busy = state_r != dlls_pkg::S_IDLE &&
                 state_r != dlls_pkg::S_DONE;
   assign tm_load = ddr_nxt.cmd != dlls_pkg::CMD_NOP ||
                    (state_r == dlls_pkg::S_CKSRX && tm_exp) ||
                    (state_r == dlls_pkg::S_FREQ && clk_ok_r);
   assign dl_load = state_r == dlls_pkg::S_MR0RST && tm_exp;
   assign zq_load = state_r == dlls_pkg::S_ZQ && tm_exp;
   // next pins and the wait that follows what is issued
   always_comb begin
      ddr_nxt      = ddr;
      ddr_nxt.cmd  = dlls_pkg::CMD_NOP;
      ddr_nxt.ba   = 3'h0;
      ddr_nxt.addr = 16'h0;
      tm_val       = t_mod_r;
      case (state_r)
         dlls_pkg::S_MR1OFF: if (tm_exp) begin
            ddr_nxt = mrs(3'h1, mr1_r | 16'h0001);
            tm_val  = t_mod_r;
         end
         dlls_pkg::S_SRE: if (tm_exp) begin
            ddr_nxt.cmd = dlls_pkg::CMD_SRE;
            ddr_nxt.cke = 1'b0;
            ddr_nxt.odt = 1'b0;
            tm_val      = t_cksre_r;
         end
         dlls_pkg::S_FREQ: tm_val = t_cksrx_r;
         dlls_pkg::S_CKSRX: if (tm_exp) begin
            ddr_nxt.cke = 1'b1;                       // exit via nop
            ddr_nxt.odt = 1'b0;
            tm_val      = t_xs_r;
         end
         dlls_pkg::S_MR1ON: if (tm_exp) begin
            ddr_nxt = mrs(3'h1, mr1_r & 16'hfffe);
            tm_val  = t_mrd_r;
         end
         dlls_pkg::S_MR0RST: if (tm_exp) begin
            ddr_nxt = mrs(3'h0, mr0_r | 16'h0100);
            tm_val  = t_mrd_r;
         end
         dlls_pkg::S_MRUPD: if (tm_exp) begin
            if (to_on_r)
               ddr_nxt = mrs(3'h2, mr2_r);
            else
               ddr_nxt = mrs(3'h2, {mr2_r[15:6], dlls_pkg::MR2_CWL6,
                                    mr2_r[2:0]});
            tm_val = t_mod_r;
         end
         dlls_pkg::S_ZQ: if (tm_exp) begin
            ddr_nxt.cmd = dlls_pkg::CMD_ZQCL;
            ddr_nxt.addr = 16'h0400;
            tm_val      = t_mod_r;
         end
         default: ;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         ddr <= '{cke: 1'b1, odt: 1'b0, cmd: dlls_pkg::CMD_NOP,
                  ba: 3'h0, addr: 16'h0};
      else
         ddr <= ddr_nxt;
   end
   // state transitions
   always_ff @(posedge aclk) begin
      if (!aresetn)
         state_r <= dlls_pkg::S_IDLE;
      else begin
         case (state_r)
            dlls_pkg::S_IDLE, dlls_pkg::S_DONE: if (go_pulse)
               state_r <= s_axi_wdata[dlls_pkg::CTRL_TO_ON] ?
                          dlls_pkg::S_SRE : dlls_pkg::S_MR1OFF;
            dlls_pkg::S_MR1OFF: if (tm_exp) state_r <= dlls_pkg::S_SRE;
            dlls_pkg::S_SRE: if (tm_exp) state_r <= dlls_pkg::S_CKSRE;
            dlls_pkg::S_CKSRE: if (tm_exp) state_r <= dlls_pkg::S_FREQ;
            dlls_pkg::S_FREQ: if (clk_ok_r) state_r <= dlls_pkg::S_CKSRX;
            dlls_pkg::S_CKSRX: if (tm_exp) state_r <= dlls_pkg::S_XS;
            dlls_pkg::S_XS: if (tm_exp)
               state_r <= to_on_r ? dlls_pkg::S_MR1ON : dlls_pkg::S_MRUPD;
            dlls_pkg::S_MR1ON: if (tm_exp) state_r <= dlls_pkg::S_MR0RST;
            dlls_pkg::S_MR0RST: if (tm_exp) state_r <= dlls_pkg::S_MRUPD;
            dlls_pkg::S_MRUPD: if (tm_exp)
               state_r <= zq_r ? dlls_pkg::S_ZQ : dlls_pkg::S_FINAL;
            dlls_pkg::S_ZQ: if (tm_exp) state_r <= dlls_pkg::S_FINAL;
            dlls_pkg::S_FINAL: if (tm_exp)
               state_r <= dlls_pkg::S_DONE;
            default: state_r <= dlls_pkg::S_IDLE;
         endcase
      end
   end

   // sticky completion and zq flags, cleared by a new run
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         done_r      <= 1'b0;
         zq_issued_r <= 1'b0;
      end else begin
         if (state_r == dlls_pkg::S_FINAL && tm_exp)
            done_r <= 1'b1;
         else if (go_pulse && !busy)
            done_r <= 1'b0;
         if (zq_load)
            zq_issued_r <= 1'b1;
         else if (go_pulse && !busy)
            zq_issued_r <= 1'b0;
      end
   end

   // outside is cleared for frequency change only in self refresh
   assign freq_change_ok = state_r == dlls_pkg::S_FREQ;
   // dll lock and zq done gate the user-visible ready
   assign dll_locked = !to_on_r || (done_r && dl_exp);
   assign ready_out  = done_r && dll_locked &&
                       (!zq_issued_r || zq_exp);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence sr_entry_s;
      state_r == dlls_pkg::S_SRE && tm_exp;
   endsequence
   cke_low_sr_a: assert property (@(posedge aclk) disable iff (!aresetn)
      sr_entry_s |=> !ddr.cke && ddr.cmd == dlls_pkg::CMD_SRE)
      else $error("self refresh entry not driven");
   freq_only_sr_a: assert property (@(posedge aclk) disable iff (!aresetn)
      freq_change_ok |-> !ddr.cke)
      else $error("frequency window outside self refresh");
   cke_held_a: assert property (@(posedge aclk) disable iff (!aresetn)
      state_r inside {dlls_pkg::S_XS, dlls_pkg::S_MR1ON,
                      dlls_pkg::S_MR0RST, dlls_pkg::S_MRUPD}
      |-> ddr.cke && !ddr.odt)
      else $error("cke or odt wrong after exit");
   dll_on_mr1_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(state_r == dlls_pkg::S_MR0RST) |-> ddr.cmd == dlls_pkg::CMD_MRS
      && ddr.ba == 3'h1 && !ddr.addr[dlls_pkg::MR1_DLL_DIS])
      else $error("dll enable write missing");
   dll_rst_a: assert property (@(posedge aclk) disable iff (!aresetn)
      dl_load |=> ddr.cmd == dlls_pkg::CMD_MRS && ddr.ba == 3'h0 &&
      ddr.addr[dlls_pkg::MR0_DLL_RST])
      else $error("dll reset write missing");
   dll_off_mr1_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(state_r == dlls_pkg::S_SRE) && !to_on_r |->
      ddr.addr[dlls_pkg::MR1_DLL_DIS])
      else $error("dll disable write missing");
   mrd_space_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ddr.cmd == dlls_pkg::CMD_MRS |=>
      ddr.cmd == dlls_pkg::CMD_NOP [*3])
      else $error("mode writes too close");
   cwl_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ddr.cmd == dlls_pkg::CMD_MRS && ddr.ba == 3'h2 && !to_on_r |->
      ddr.addr[5:3] == dlls_pkg::MR2_CWL6)
      else $error("dll off cwl not six");
   ready_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ready_out |-> state_r == dlls_pkg::S_DONE && dll_locked)
      else $error("ready before lock");
endmodule : dlls_seq

// *** verif/dlls_ddr_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// sdram stand-in: mode registers, self refresh and dll relock
// ----------------------------------------------------------------
module dlls_ddr_model (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire dlls_pkg::dlls_pins_s ddr,
   input  wire logic                 freq_change_ok,
   input  wire logic                 dll_locked,
   input  wire logic                 ready_out,
   input  wire logic [15:0]          t_dllk,
   input  wire logic [15:0]          t_zqop
);
   logic [15:0] mr [0:3];
   logic        in_sr, relock, freq_q;
   int          cyc, last, viol;
   int          lock_cnt = 0;
   int          zq_cnt = 0;
   int          gaps[$];
   // gap to the previous event, in real clock edges, not in time
   task automatic log_ev();
      gaps.push_back(cyc - last);
      last = cyc;
   endtask : log_ev
   // pins latched on each rising edge, as the device sees them
   always @(posedge aclk) begin
      cyc++;
      if (!aresetn) begin
         in_sr  = 1'b0;
         relock = 1'b0;
      end else begin
         if (lock_cnt > 0) begin
            lock_cnt--;
            if (lock_cnt == 0)
               relock = 1'b0;
         end
         if (zq_cnt > 0)
            zq_cnt--;
         if (ddr.cmd === dlls_pkg::CMD_SRE && ddr.cke === 1'b0) begin
            if (ddr.odt !== 1'b0 || relock)
               viol++;
            in_sr = 1'b1;
            log_ev();
         end else if (in_sr && ddr.cke === 1'b1) begin
            in_sr  = 1'b0;
            relock = 1'b1;
            log_ev();
         end
         if (freq_change_ok === 1'b1 && !freq_q)
            log_ev();
         // the clock may only move while in self refresh
         if (freq_change_ok === 1'b1 && !in_sr)
            viol++;
         if (ddr.cmd === dlls_pkg::CMD_MRS && ddr.cke === 1'b1) begin
            mr[ddr.ba[1:0]] = ddr.addr;
            if (ddr.ba == 3'h0 && ddr.addr[8])
               lock_cnt = t_dllk;
            if (ddr.ba == 3'h1 && ddr.addr[0])
               relock = 1'b0;
            log_ev();
         end
         if (ddr.cmd === dlls_pkg::CMD_ZQCL) begin
            zq_cnt = t_zqop;
            log_ev();
         end
         // cke high and odt low from exit until relock ends
         if (relock && (ddr.cke !== 1'b1 || ddr.odt !== 1'b0))
            viol++;
         if ((dll_locked === 1'b1 || ready_out === 1'b1) && lock_cnt > 0)
            viol++;
         if (ready_out === 1'b1 && zq_cnt > 0)
            viol++;
      end
      freq_q = freq_change_ok;
   end
endmodule : dlls_ddr_model

// *** verif/dll_mode_switch_sequencer_bench.sv ***
`timescale 1ns/1ps
module dll_mode_switch_sequencer_bench;
   // ----------------------------------------------------------------
   // signals, instances and bus tasks
   // ----------------------------------------------------------------
   logic        aclk, aresetn, freq_change_ok, dll_locked, ready_out;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   int          mismatches = 0;
   int          checks_done = 0;
   dlls_pkg::dlls_pins_s ddr;
   // waits: cksre cksrx xs mrd mod dllk zqoper; short ones keep runs brief
   localparam logic [31:0] DFLT [7] = '{32'h1, 32'h1, 32'h2, 32'h4,
                                        32'hc, 32'h200, 32'h100};
   localparam logic [31:0] FAST [7] = '{32'h2, 32'h2, 32'h3, 32'h4,
                                        32'h5, 32'h28, 32'h8};
   dlls_seq i_dlls_seq (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .ddr, .freq_change_ok, .dll_locked,
      .ready_out
   );
   dlls_ddr_model i_dlls_ddr_model (
      .aclk, .aresetn, .ddr, .freq_change_ok, .dll_locked, .ready_out,
      .t_dllk(FAST[5][15:0]), .t_zqop(FAST[6][15:0])
   );
   task automatic chk(input string what, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do @(posedge aclk); while (s_axi_awready !== 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid  <= 1'b0;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      chk("bresp", s_axi_bresp, 32'h0); // bready stays up between calls
   endtask : axi_write
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata; // rready stays up between calls
      chk("rresp", s_axi_rresp, 32'h0);
   endtask : axi_read
   // one switch; a timing write while busy must be ignored
   task automatic run_switch(input logic [31:0] ctrl);
      i_dlls_ddr_model.gaps.delete();
      axi_write(dlls_pkg::REG_CTRL, ctrl);
      while (freq_change_ok !== 1'b1)
         @(posedge aclk);
      axi_write(dlls_pkg::REG_T_XS, 32'h9);
      repeat (4) @(posedge aclk);
      axi_write(dlls_pkg::REG_CTRL, 32'h10);
      while (ready_out !== 1'b1)
         @(posedge aclk);
      axi_read(dlls_pkg::REG_T_XS, rd);
      chk("busy_write", rd, FAST[2]);
   endtask : run_switch
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   // free-running bus clock
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   // hang guard, far beyond both switches
   initial begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      aresetn       = 1'b0;
      s_axi_awaddr  = 8'h00;
      s_axi_araddr  = 8'h00;
      s_axi_wdata   = 32'h0;
      s_axi_wstrb   = 4'hf;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid  = 1'b0;
      s_axi_bready  = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready  = 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("idle_pins", {ddr.cke, ddr.odt, ddr.cmd, freq_change_ok, ready_out},
          {2'b10, dlls_pkg::CMD_NOP, 2'b00});
      for (int i = 0; i < 7; i++) begin
         axi_read(8'(dlls_pkg::REG_T_CKSRE + 4 * i), rd);
         chk("timing_default", rd, DFLT[i]);
         axi_write(8'(dlls_pkg::REG_T_CKSRE + 4 * i), FAST[i]);
         axi_read(8'(dlls_pkg::REG_T_CKSRE + 4 * i), rd);
         chk("timing_set", rd, FAST[i]);
      end
      axi_read(8'h40, rd);
      chk("unmapped", rd, 32'h0);
      axi_write(dlls_pkg::REG_MR0, 32'h20);
      axi_write(dlls_pkg::REG_MR1, 32'h4);
      axi_write(dlls_pkg::REG_MR2, 32'h10);
      // off to on, odt enable bit set but odt held low, long calibration
      run_switch(32'hf);
      chk("gap_cksre", i_dlls_ddr_model.gaps[1] >= 2, 32'h1);
      chk("gap_cksrx", i_dlls_ddr_model.gaps[2] >= 3, 32'h1);
      // exit is a nop followed by its own wait state: t_xs + 2 edges
      chk("gap_xs", i_dlls_ddr_model.gaps[3], 32'h5);
      chk("gap_mrd_a", i_dlls_ddr_model.gaps[4], 32'h5);
      chk("gap_mrd_b", i_dlls_ddr_model.gaps[5], 32'h5);
      chk("gap_mod_zq", i_dlls_ddr_model.gaps[6], 32'h6);
      chk("mr1_dll_on", i_dlls_ddr_model.mr[1][0], 32'h0);
      chk("mr0_dll_rst", i_dlls_ddr_model.mr[0][8], 32'h1);
      chk("mr2_update", i_dlls_ddr_model.mr[2], 32'h10);
      axi_read(dlls_pkg::REG_STATUS, rd);
      chk("status_on", rd & 32'h30b, 32'h30a);
      // on to off, no termination, no calibration
      run_switch(32'h1);
      chk("off_gap_mod", i_dlls_ddr_model.gaps[1], 32'h6);
      chk("off_gap_xs", i_dlls_ddr_model.gaps[4], 32'h5);
      chk("mr1_dll_off", i_dlls_ddr_model.mr[1][0], 32'h1);
      chk("mr2_cwl6", i_dlls_ddr_model.mr[2][5:3], dlls_pkg::MR2_CWL6);
      chk("pin_faults", i_dlls_ddr_model.viol, 32'h0);
      tally_and_finish();
   end
endmodule : dll_mode_switch_sequencer_bench
